// file: verilog/dmap_port.sv
// dmap_port: memory access port end, arbitrating six requestor channels onto main memory
//
// Contract
// - up to six channels interleaved, fixed priority
// - channels 2..7 each request, write, acknowledge
// - highest-numbered requesting channel wins
// - requestor asserts its request for one transfer
// - write select true writes, false reads
// - acknowledge of chosen channel starts transfer
// - requestor drives buses only while acknowledged
// - read word held strobe 2 through strobe 4
// - requestor captures read data at strobe 2
// - request steady from strobe 2 to strobe 4
// - request withdrawn before next strobe 0
// - transfers run without processor involvement
// - address 15 bits, data buses 16 bits
// - every link signal is active low
`timescale 1ns/1ps
module dmap_port (
    input  wire logic                     clk,
    input  wire logic                     rst,
    dmap_if.port                          link,
    output logic                          mem_en,
    output logic                          mem_we,
    output logic [dmap_pkg::AW-1:0]       mem_addr,
    output logic [dmap_pkg::DW-1:0]       mem_wdata,
    input  wire logic [dmap_pkg::DW-1:0]  mem_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [dmap_pkg::PH_W-1:0] phase;
        logic                      s0_n;
        logic                      s2_n;
        logic                      s4_n;
        logic                      kclk_n;
        logic                      xrst_n;
        logic [dmap_pkg::PH_W-1:0] xrst_cnt;
        logic [dmap_pkg::NCH-1:0]  req_m;
        logic [dmap_pkg::NCH-1:0]  req_s;
        logic [dmap_pkg::NCH-1:0]  wsel_m;
        logic [dmap_pkg::NCH-1:0]  wsel_s;
        logic [dmap_pkg::AW-1:0]   addr_m;
        logic [dmap_pkg::AW-1:0]   addr_s;
        logic [dmap_pkg::DW-1:0]   data_m;
        logic [dmap_pkg::DW-1:0]   data_s;
        logic [dmap_pkg::NCH-1:0]  pend;
        logic                      pend_we;
        logic [dmap_pkg::NCH-1:0]  grant_n;
        logic                      acc_we;
        logic                      rd_valid;
        logic [dmap_pkg::DW-1:0]   rd_hold;
        logic [dmap_pkg::DW-1:0]   dout_n;
        logic                      mem_en;
        logic                      mem_we;
        logic [dmap_pkg::AW-1:0]   mem_addr;
        logic [dmap_pkg::DW-1:0]   mem_wdata;
    } dmap_port_t;

    // reset image: strobes and buses idle high, ext reset asserted, no grant
    localparam dmap_port_t RESET_VAL = '{
        phase:     dmap_pkg::PH_LAST,  // wraps to 0 at once
        s0_n:      1'h1,
        s2_n:      1'h1,
        s4_n:      1'h1,
        kclk_n:    1'h1,
        xrst_n:    1'h0,
        xrst_cnt:  dmap_pkg::XRST_INIT,
        req_m:     '1,
        req_s:     '1,
        wsel_m:    '1,
        wsel_s:    '1,
        addr_m:    '1,
        addr_s:    '1,
        data_m:    '1,
        data_s:    '1,
        pend:      '0,
        pend_we:   1'h0,
        grant_n:   '1,
        acc_we:    1'h0,
        rd_valid:  1'h0,
        rd_hold:   '0,
        dout_n:    '1,
        mem_en:    1'h0,
        mem_we:    1'h0,
        mem_addr:  '0,
        mem_wdata: '0
    };

    dmap_port_t r;
    dmap_port_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // fixed priority: keep only the highest set bit, so channel 7 beats all

    function automatic logic [dmap_pkg::NCH-1:0] pick_top(
        input logic [dmap_pkg::NCH-1:0] want
    );
        logic [dmap_pkg::NCH-1:0] one;
        one = '0;
        for (int i = 0; i < dmap_pkg::NCH; i++) begin
            if (want[i]) begin
                one = '0;
                one[i] = 1'h1;
            end
        end
        return one;
    endfunction : pick_top

    // true when p lies in [lo, lo + width)
    function automatic logic in_span(
        input logic [dmap_pkg::PH_W-1:0] p,
        input logic [dmap_pkg::PH_W-1:0] lo
    );
        return (p >= lo) && (p < lo + dmap_pkg::PH_STB);
    endfunction : in_span

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    logic [dmap_pkg::PH_W-1:0] np;
    logic [dmap_pkg::NCH-1:0]  win;

    always_comb begin
        next_r = r;
        win    = '0;
        // free-running memory cycle; nothing here waits on the processor
        np = (r.phase == dmap_pkg::PH_LAST) ? '0 : r.phase + dmap_pkg::PH_W'(1);
        next_r.phase = np;

        // timing strobes and external clock all requestors follow
        next_r.s0_n   = ~in_span(np, '0);
        next_r.s2_n   = ~in_span(np, dmap_pkg::PH_S2);
        next_r.s4_n   = ~in_span(np, dmap_pkg::PH_S4);
        next_r.kclk_n = ~(np < dmap_pkg::PH_HALF);

        // ext reset stays asserted a full memory cycle after local reset
        if (r.xrst_cnt != '0) begin
            next_r.xrst_cnt = r.xrst_cnt - dmap_pkg::PH_W'(1);
        end
        next_r.xrst_n = (r.xrst_cnt == '0);

        // two-flop synchronisers on every link input
        next_r.req_m  = link.mem_req_n;
        next_r.req_s  = r.req_m;
        next_r.wsel_m = link.write_select_n;
        next_r.wsel_s = r.wsel_m;
        next_r.addr_m = link.port_addr_in_n;
        next_r.addr_s = r.addr_m;
        next_r.data_m = link.port_data_in_n;
        next_r.data_s = r.data_m;

        // decide once per cycle from requests as they stand at strobe 2
        if (np == dmap_pkg::PH_S2) begin
            win = r.xrst_n ? pick_top(~r.req_s) : '0;
            next_r.pend    = win;
            next_r.pend_we = |(win & ~r.wsel_s);
        end

        // acknowledge goes out at strobe 4 and holds one whole cycle
        if (np == dmap_pkg::PH_S4) begin
            next_r.grant_n = ~r.pend;                             // one-hot, at most one
            next_r.acc_we  = r.pend_we;
        end

        // memory access at strobe 0 of the granted cycle; buses were gated on by
        // the acknowledge for a full strobe-4 gap, so the synced copy has settled
        next_r.mem_en = 1'h0;
        if (np == '0) begin
            next_r.mem_en    = ~&r.grant_n;
            next_r.mem_we    = r.acc_we;
            next_r.mem_addr  = ~r.addr_s;
            next_r.mem_wdata = ~r.data_s;
            next_r.rd_valid  = ~&r.grant_n & ~r.acc_we;
        end
        if (r.phase == dmap_pkg::PH_RD) begin
            next_r.rd_hold = mem_rdata;
        end

        // read word on the output bus from strobe 2 to the end of strobe 4
        if (r.rd_valid && np >= dmap_pkg::PH_S2 && np < dmap_pkg::PH_S4E) begin
            next_r.dout_n = ~r.rd_hold;
        end else begin
            next_r.dout_n = '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers: reset drops every acknowledge and raises ext reset

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= RESET_VAL;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign link.mem_grant_n      = r.grant_n;
    assign link.port_data_out_n  = r.dout_n;
    assign link.cycle_strobe_0_n = r.s0_n;
    assign link.cycle_strobe_2_n = r.s2_n;
    assign link.cycle_strobe_4_n = r.s4_n;
    assign link.ext_clock_out_n  = r.kclk_n;
    assign link.ext_reset_out_n  = r.xrst_n;
    assign mem_en                = r.mem_en;
    assign mem_we                = r.mem_we;
    assign mem_addr              = r.mem_addr;
    assign mem_wdata             = r.mem_wdata;

endmodule : dmap_port

// file: verilog/dmap_pkg.sv
// dmap_pkg: shared widths, timing constants and host-end state codes of the memory access port
package dmap_pkg;
    // link widths
    localparam int NCH = 6;            // channels 2..7, bit 0 is channel 2
    localparam int AW  = 15;           // address input bus
    localparam int DW  = 16;           // data input and output buses
    localparam int PH_W = 7;           // memory cycle phase counter width

    // times in ns, as the memory cycle is laid out
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_CYCLE_NS    = 1750;  // one memory cycle
    localparam int T_S2_NS       = 700;   // cycle_strobe_2 start within the cycle
    localparam int T_S4_NS       = 1400;  // cycle_strobe_4 start within the cycle
    localparam int T_STB_NS      = 175;   // width of each timing strobe
    localparam int T_XRST_NS     = 1750;  // ext reset stretch after local reset

    // cycle counts, rounded down
    localparam int CYC_CLKS  = T_CYCLE_NS / CLK_PERIOD_NS;
    localparam int S2_CLKS   = T_S2_NS / CLK_PERIOD_NS;
    localparam int S4_CLKS   = T_S4_NS / CLK_PERIOD_NS;
    localparam int STB_CLKS  = T_STB_NS / CLK_PERIOD_NS;
    localparam int XRST_CLKS = T_XRST_NS / CLK_PERIOD_NS;

    // phase points of the cycle
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(CYC_CLKS - 1);
    localparam logic [PH_W-1:0] PH_S2   = PH_W'(S2_CLKS);
    localparam logic [PH_W-1:0] PH_S4   = PH_W'(S4_CLKS);
    localparam logic [PH_W-1:0] PH_STB  = PH_W'(STB_CLKS);
    localparam logic [PH_W-1:0] PH_S4E  = PH_W'(S4_CLKS + STB_CLKS);
    localparam logic [PH_W-1:0] PH_HALF = PH_W'(CYC_CLKS / 2);
    localparam logic [PH_W-1:0] PH_RD   = PH_W'(2);  // read word captured here
    localparam logic [PH_W-1:0] XRST_INIT = PH_W'(XRST_CLKS);

    // host-end channel states
    typedef enum logic [2:0] {
        DMAP_IDLE  = 3'h1,
        DMAP_WAIT  = 3'h2,
        DMAP_GRANT = 3'h4
    } dmap_chan_t;
endpackage : dmap_pkg

// file: verilog/dmap_if.sv
// dmap_if: the memory access port link between the port and its requestors
`timescale 1ns/1ps
interface dmap_if;
    // every signal is active low on the link
    logic [dmap_pkg::NCH-1:0] mem_req_n;
    logic [dmap_pkg::NCH-1:0] write_select_n;
    logic [dmap_pkg::NCH-1:0] mem_grant_n;
    logic [dmap_pkg::AW-1:0]  port_addr_in_n;
    logic [dmap_pkg::DW-1:0]  port_data_in_n;
    logic [dmap_pkg::DW-1:0]  port_data_out_n;
    logic                     cycle_strobe_0_n;
    logic                     cycle_strobe_2_n;
    logic                     cycle_strobe_4_n;
    logic                     ext_clock_out_n;
    logic                     ext_reset_out_n;

    modport port (
        input  mem_req_n,
        input  write_select_n,
        input  port_addr_in_n,
        input  port_data_in_n,
        output mem_grant_n,
        output port_data_out_n,
        output cycle_strobe_0_n,
        output cycle_strobe_2_n,
        output cycle_strobe_4_n,
        output ext_clock_out_n,
        output ext_reset_out_n
    );

    modport req (
        output mem_req_n,
        output write_select_n,
        output port_addr_in_n,
        output port_data_in_n,
        input  mem_grant_n,
        input  port_data_out_n,
        input  cycle_strobe_0_n,
        input  cycle_strobe_2_n,
        input  cycle_strobe_4_n,
        input  ext_clock_out_n,
        input  ext_reset_out_n
    );
endinterface : dmap_if

// file: verilog/dmap_req.sv
// dmap_req: requestor end, six channels of commands turned into port transfers
`timescale 1ns/1ps
module dmap_req (
    input  wire logic                                     clk,
    input  wire logic                                     rst,
    dmap_if.req                                           link,
    input  wire logic [dmap_pkg::NCH-1:0]                 cmd_valid,
    input  wire logic [dmap_pkg::NCH-1:0]                 cmd_write,
    input  wire logic [dmap_pkg::NCH-1:0][dmap_pkg::AW-1:0] cmd_addr,
    input  wire logic [dmap_pkg::NCH-1:0][dmap_pkg::DW-1:0] cmd_wdata,
    output logic [dmap_pkg::NCH-1:0]                      cmd_ready,
    output logic [dmap_pkg::NCH-1:0]                      done,
    output logic [dmap_pkg::DW-1:0]                       rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        dmap_pkg::dmap_chan_t [dmap_pkg::NCH-1:0]         st;
        logic [dmap_pkg::NCH-1:0]                         we;
        logic [dmap_pkg::NCH-1:0][dmap_pkg::AW-1:0]       addr;
        logic [dmap_pkg::NCH-1:0][dmap_pkg::DW-1:0]       wdata;
        logic [dmap_pkg::NCH-1:0]                         gnt_m;
        logic [dmap_pkg::NCH-1:0]                         gnt_s;
        logic                                             s2_m;
        logic                                             s2_s;
        logic                                             s2_d;
        logic                                             s4_m;
        logic                                             s4_s;
        logic                                             s4_d;
        logic                                             s0_m;
        logic                                             s0_s;
        logic                                             xr_m;
        logic                                             xr_s;
        logic [dmap_pkg::DW-1:0]                          dout_m;
        logic [dmap_pkg::DW-1:0]                          dout_s;
        logic                                             win;
        logic [dmap_pkg::NCH-1:0]                         req_n;
        logic [dmap_pkg::NCH-1:0]                         wsel_n;
        logic [dmap_pkg::AW-1:0]                          addr_n;
        logic [dmap_pkg::DW-1:0]                          data_n;
        logic [dmap_pkg::NCH-1:0]                         ready;
        logic [dmap_pkg::NCH-1:0]                         done;
        logic [dmap_pkg::DW-1:0]                          rdata;
    } dmap_req_t;

    dmap_req_t r;
    dmap_req_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic; link inputs pass two flops, inverted only after that

    logic s2_rise;
    logic s4_fall;

    always_comb begin
        next_r        = r;
        next_r.gnt_m  = link.mem_grant_n;
        next_r.gnt_s  = r.gnt_m;
        next_r.s2_m   = link.cycle_strobe_2_n;
        next_r.s2_s   = r.s2_m;
        next_r.s2_d   = r.s2_s;
        next_r.s4_m   = link.cycle_strobe_4_n;
        next_r.s4_s   = r.s4_m;
        next_r.s4_d   = r.s4_s;
        next_r.s0_m   = link.cycle_strobe_0_n;
        next_r.s0_s   = r.s0_m;
        next_r.xr_m   = link.ext_reset_out_n;
        next_r.xr_s   = r.xr_m;
        next_r.dout_m = link.port_data_out_n;
        next_r.dout_s = r.dout_m;
        s2_rise = r.s2_d & ~r.s2_s;
        s4_fall = ~r.s4_d & r.s4_s;
        // closed from strobe 0 to the end of strobe 4: no request lands in strobe 2..4
        if (!r.s0_s) begin
            next_r.win = 1'h1;
        end else if (s4_fall) begin
            next_r.win = 1'h0;
        end
        next_r.done   = '0;
        next_r.addr_n = '1;
        next_r.data_n = '1;
        for (int i = 0; i < dmap_pkg::NCH; i++) begin
            unique case (r.st[i])
                dmap_pkg::DMAP_IDLE: begin
                    if (cmd_valid[i]) begin
                        next_r.st[i]    = dmap_pkg::DMAP_WAIT;
                        next_r.we[i]    = cmd_write[i];
                        next_r.addr[i]  = cmd_addr[i];
                        next_r.wdata[i] = cmd_wdata[i];
                    end
                end
                dmap_pkg::DMAP_WAIT: begin
                    // raise request only outside the strobe window
                    if (!r.win && !next_r.win) begin
                        next_r.req_n[i]  = 1'h0;
                        next_r.wsel_n[i] = ~r.we[i];
                    end
                    if (!r.gnt_s[i] && !r.req_n[i]) begin
                        next_r.st[i] = dmap_pkg::DMAP_GRANT;
                    end
                end
                dmap_pkg::DMAP_GRANT: begin
                    // withdraw once the window closes, well before next strobe 0
                    if (!r.win) begin
                        next_r.req_n[i]  = 1'h1;
                        next_r.wsel_n[i] = 1'h1;
                    end
                    // buses gated by own acknowledge only
                    if (!r.gnt_s[i]) begin
                        next_r.addr_n = ~r.addr[i];
                        next_r.data_n = ~r.wdata[i];
                    end
                    // capture read word at strobe 2 while acknowledged
                    if (s2_rise && !r.gnt_s[i]) begin
                        next_r.st[i]   = dmap_pkg::DMAP_IDLE;
                        next_r.done[i] = 1'h1;
                        next_r.rdata   = ~r.dout_s;
                    end
                end
                default: begin
                    next_r.st[i] = dmap_pkg::DMAP_IDLE;
                end
            endcase
            next_r.ready[i] = (next_r.st[i] == dmap_pkg::DMAP_IDLE);
        end
        // port reset clears every channel
        if (!r.xr_s) begin
            next_r.st     = {dmap_pkg::NCH{dmap_pkg::DMAP_IDLE}};
            next_r.req_n  = '1;
            next_r.wsel_n = '1;
            next_r.ready  = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; link lines idle at the false (high) level

    always_ff @(posedge clk) begin
        if (rst) begin
            r        <= '0;
            r.st     <= {dmap_pkg::NCH{dmap_pkg::DMAP_IDLE}};
            r.gnt_m  <= '1;
            r.gnt_s  <= '1;
            r.s2_m   <= 1'h1;
            r.s2_s   <= 1'h1;
            r.s2_d   <= 1'h1;
            r.s4_m   <= 1'h1;
            r.s4_s   <= 1'h1;
            r.s4_d   <= 1'h1;
            r.s0_m   <= 1'h1;
            r.s0_s   <= 1'h1;
            r.win    <= 1'h1;
            r.dout_m <= '1;
            r.dout_s <= '1;
            r.req_n  <= '1;
            r.wsel_n <= '1;
            r.addr_n <= '1;
            r.data_n <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign link.mem_req_n      = r.req_n;
    assign link.write_select_n = r.wsel_n;
    assign link.port_addr_in_n = r.addr_n;
    assign link.port_data_in_n = r.data_n;
    assign cmd_ready           = r.ready;
    assign done                = r.done;
    assign rdata               = r.rdata;

endmodule : dmap_req

// file: bench/dmap_sva.sv
// dmap_sva: timing, arbitration and reset checks on the memory access port link
`timescale 1ns/1ps
module dmap_sva (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic [dmap_pkg::NCH-1:0] mem_req_n,
    input wire logic [dmap_pkg::NCH-1:0] mem_grant_n,
    input wire logic [dmap_pkg::DW-1:0]  port_data_out_n,
    input wire logic                     cycle_strobe_0_n,
    input wire logic                     cycle_strobe_2_n,
    input wire logic                     cycle_strobe_4_n,
    input wire logic                     ext_clock_out_n,
    input wire logic                     ext_reset_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    // cycles the read word has stood unchanged; idle ones restart the count
    logic [6:0] run_len;
    always_ff @(posedge clk) begin
        if (rst || (&port_data_out_n) || $changed(port_data_out_n)) begin
            run_len <= 7'h00;
        end else begin
            run_len <= run_len + 7'h01;
        end
    end

    // strobe 2 seen, strobe 4 not yet over
    logic in_win;
    always_ff @(posedge clk) begin
        if (rst || $rose(cycle_strobe_4_n)) begin
            in_win <= 1'h0;
        end else if (!cycle_strobe_2_n) begin
            in_win <= 1'h1;
        end
    end

    ////////////////////////////////////////
    // strobe pulse shape and phase order within one memory cycle
    sequence low8_s(sig);
        !sig [*8] ##1 sig;
    endsequence
    sequence phases_s;
        ##35 $fell(cycle_strobe_2_n) ##35 $fell(cycle_strobe_4_n);
    endsequence

    one_grant_a: assert property ($onehot0(~mem_grant_n))
        else $error("more than one acknowledge low");
    grant_step_a: assert property ($changed(mem_grant_n) |-> !cycle_strobe_4_n)
        else $error("acknowledge moved outside strobe 4");
    strobe_width_a: assert property ($fell(cycle_strobe_0_n) |-> low8_s(cycle_strobe_0_n))
        else $error("strobe 0 pulse width wrong");
    strobe_order_a: assert property ($fell(cycle_strobe_0_n) |-> phases_s)
        else $error("strobe 2 or 4 out of place");
    cycle_len_a: assert property ($fell(cycle_strobe_0_n) |-> ##87 $fell(cycle_strobe_0_n))
        else $error("memory cycle length wrong");
    ext_clock_a: assert property ($fell(cycle_strobe_0_n) |-> !ext_clock_out_n ##43 ext_clock_out_n)
        else $error("external clock phase wrong");
    reset_state_a: assert property ($fell(rst) |-> !ext_reset_out_n && (&mem_grant_n))
        else $error("reset state of link wrong");
    early_grant_a: assert property (!ext_reset_out_n |-> &mem_grant_n)
        else $error("acknowledge during external reset");
    data_hold_a: assert property ($fell(cycle_strobe_4_n) && !(&port_data_out_n) |-> run_len >= 7'h1e)
        else $error("read word not held from strobe 2");
    data_close_a: assert property ($rose(cycle_strobe_4_n) |=> &port_data_out_n)
        else $error("read word left on bus after strobe 4");
    req_drop_a: assert property ($fell(cycle_strobe_0_n) |-> &(mem_req_n | mem_grant_n))
        else $error("granted request still up at strobe 0");
    req_steady_a: assert property (in_win || !cycle_strobe_2_n |-> $stable(mem_req_n))
        else $error("request moved between strobe 2 and strobe 4");
endmodule : dmap_sva

// file: bench/memory_access_port_arbiter_test.sv
// memory_access_port_arbiter_test: port and requestors joined, word memory behind the port
`timescale 1ns/1ps
module memory_access_port_arbiter_test;
    logic                                       clk = 1'b0;
    logic                                       rst = 1'b1;
    logic [dmap_pkg::NCH-1:0]                   cmd_valid = 6'h00;
    logic [dmap_pkg::NCH-1:0]                   cmd_write = 6'h00;
    logic [dmap_pkg::NCH-1:0][dmap_pkg::AW-1:0] cmd_addr = '0;
    logic [dmap_pkg::NCH-1:0][dmap_pkg::DW-1:0] cmd_wdata = '0;
    logic [dmap_pkg::NCH-1:0]                   cmd_ready;
    logic [dmap_pkg::NCH-1:0]                   done;
    logic [dmap_pkg::DW-1:0]                    rdata;
    logic                                       mem_en;
    logic                                       mem_we;
    logic [dmap_pkg::AW-1:0]                    mem_addr;
    logic [dmap_pkg::DW-1:0]                    mem_wdata;
    logic [dmap_pkg::DW-1:0]                    mem_rdata = 16'h0000;
    logic [dmap_pkg::DW-1:0]                    mem [0:32767];
    int                                         errors = 0;
    int                                         tests_run = 0;

    always #10 clk = ~clk;

    dmap_if link_if ();
    dmap_port dmap_port_i (.clk(clk), .rst(rst), .link(link_if), .mem_en(mem_en),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    dmap_req dmap_req_i (.clk(clk), .rst(rst), .link(link_if), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .done(done), .rdata(rdata));
    dmap_sva dmap_sva_i (.clk(clk), .rst(rst), .mem_req_n(link_if.mem_req_n),
        .mem_grant_n(link_if.mem_grant_n), .port_data_out_n(link_if.port_data_out_n),
        .cycle_strobe_0_n(link_if.cycle_strobe_0_n), .cycle_strobe_2_n(link_if.cycle_strobe_2_n),
        .cycle_strobe_4_n(link_if.cycle_strobe_4_n), .ext_clock_out_n(link_if.ext_clock_out_n),
        .ext_reset_out_n(link_if.ext_reset_out_n));

    // word memory, one clock read latency, well inside the port's two clock allowance
    always @(posedge clk) begin
        if (mem_en === 1'b1) begin
            if (mem_we) begin
                mem[mem_addr] <= mem_wdata;
            end
            mem_rdata <= mem[mem_addr];
        end
    end

    ////////////////////////////////////////
    function automatic logic [14:0] addr_of(input int ch);
        return 15'h7fff - 15'(ch * 15'h0f0f);  // channel 2 hits the top word
    endfunction : addr_of
    function automatic logic [15:0] data_of(input int ch);
        return 16'(16'h9e37 * (ch + 1));
    endfunction : data_of

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wait_ready(input int ch);
        int n;
        for (n = 0; n < 400 && cmd_ready[ch] !== 1'b1; n++) begin
            @(posedge clk);
        end
        check("ready", 16'h0001, {15'h0000, cmd_ready[ch]});
    endtask : wait_ready

    // one transfer; d is the word written, or the word a read must return
    task automatic xfer(input int ch, input logic wr, input logic [14:0] a, input logic [15:0] d);
        int n;
        wait_ready(ch);
        cmd_valid[ch] <= 1'b1;
        cmd_write[ch] <= wr;
        cmd_addr[ch]  <= a;
        cmd_wdata[ch] <= d;
        @(posedge clk);
        cmd_valid[ch] <= 1'b0;
        for (n = 0; n < 600 && done[ch] !== 1'b1; n++) begin
            @(posedge clk);
            if (mem_en === 1'b1) begin
                check("grant", 16'h0001 << ch, {10'h000, ~link_if.mem_grant_n});
                check("addr wire", {1'b0, a}, {1'b0, ~link_if.port_addr_in_n});
                check("access", {wr, a}, {mem_we, mem_addr});
                if (wr) begin
                    check("data wire", d, ~link_if.port_data_in_n);
                end
            end
        end
        check("done", 16'h0000, {15'h0000, n == 600});
        if (!wr) begin
            check("read data", d, rdata);
            check("read wire", d, ~link_if.port_data_out_n);
        end
    endtask : xfer

    ////////////////////////////////////////
    task automatic t_reset;
        check("ext reset", 16'h0000, {15'h0000, link_if.ext_reset_out_n});
        check("grants", 16'h003f, {10'h000, link_if.mem_grant_n});
        repeat (60) @(posedge clk);
        check("ext reset held", 16'h0000, {15'h0000, link_if.ext_reset_out_n});
        $display("test reset done");
    endtask : t_reset

    // every channel writes and reads back, the top word of the address range included
    task automatic t_rw;
        for (int ch = 0; ch < 6; ch++) begin
            xfer(ch, 1'b1, addr_of(ch), data_of(ch));
            check("memory word", data_of(ch), mem[addr_of(ch)]);
            xfer(ch, 1'b0, addr_of(ch), data_of(ch));
        end
        $display("test write read done");
    endtask : t_rw

    // all six ask in the same cycle: served one per cycle, highest channel first
    task automatic t_prio;
        int n;
        int k;
        k = 0;
        for (n = 0; n < 6; n++) begin
            wait_ready(n);
            cmd_addr[n] <= addr_of(n);
        end
        cmd_write <= 6'h00;
        cmd_valid <= 6'h3f;
        @(posedge clk);
        cmd_valid <= 6'h00;
        for (n = 0; n < 1500 && k < 6; n++) begin
            @(posedge clk);
            if (done !== 6'h00) begin
                check("winner", 16'h0001 << (5 - k), {10'h000, done});
                check("winner data", data_of(5 - k), rdata);
                k++;
            end
        end
        check("served", 16'h0006, 16'(k));
        $display("test priority done");
    endtask : t_prio

    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_rw();
        t_prio();
        report_and_stop();
    end

    // twelve single transfers and one burst need about 2800 clocks; seven times that is a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : memory_access_port_arbiter_test
